// ### serial_trace_pkg.sv
// Shared constants for the serial/trace pad multiplexer.
package serial_trace_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Pad counts and widths.
    localparam int SHARED_PADS = 14;
    localparam int TRACE_WIDTH = 16;
    localparam int CS_COUNT = 4;
    localparam int DATA_LANES = 4;
    localparam int SYNC_STAGES = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Position of each serial function on the shared pad vector.
    localparam int PAD_CLOCK = 0;
    localparam int PAD_CS_BASE = 1;
    localparam int PAD_ENABLE = 5;
    localparam int PAD_OUT_BASE = 6;
    localparam int PAD_IN_BASE = 10;

    ////////////////////////////////////////////////////////////////////////////////
    // Trace data bit carried by each shared pad in trace mode, element i for pad i.
    localparam logic [SHARED_PADS-1:0][3:0] TRACE_BIT_MAP = {
        4'hF, 4'hE, 4'hD, 4'hC,
        4'hB, 4'hA, 4'h9, 4'h8,
        4'h7,
        4'h3, 4'h2, 4'h6, 4'h5,
        4'h4
    };

    // Trace data bits that have dedicated pads and never share.
    localparam int DEDICATED_DATA_BITS = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [SHARED_PADS-1:0] PAD_RESET = 14'h0000;
    localparam logic [TRACE_WIDTH-1:0] TRACE_RESET = 16'h0000;
    localparam logic TRACE_MODE_RESET = 1'b0;

    // Pad ownership.
    typedef enum logic [1:0] {
        OWNER_SERIAL = 2'b01,
        OWNER_TRACE = 2'b10
    } pad_owner_t;

endpackage : serial_trace_pkg

// ### pad_sync.sv
// Two-flop synchroniser for a group of pad inputs.
`timescale 1ns/1ps
module pad_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Asynchronous pad levels in, synchronised levels out.
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            syncOut <= '0;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule : pad_sync

// ### serial_trace_pin_mux.sv
// Pad multiplexer sharing fourteen pads between the serial port and trace input.
`timescale 1ns/1ps
module serial_trace_pin_mux #(
    parameter int SHARED = serial_trace_pkg::SHARED_PADS,
    parameter int TRACE_W = serial_trace_pkg::TRACE_WIDTH
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Module enables, from logic on the same clock.
    input wire logic serialEnable,
    input wire logic traceEnable,
    // Serial port side: per-pad drive, enable and received level.
    input wire logic [SHARED-1:0] serialOut,
    input wire logic [SHARED-1:0] serialOe,
    output logic [SHARED-1:0] serialIn,
    // Shared pads.
    input wire logic [SHARED-1:0] padIn,
    output logic [SHARED-1:0] padOut,
    output logic [SHARED-1:0] padOe,
    // Dedicated trace pads.
    input wire logic trace_in_clock_pin,
    input wire logic trace_in_sync_pin,
    input wire logic trace_in_enable_pin,
    input wire logic [1:0] traceDataPins,
    // Trace input side.
    output logic traceClock,
    output logic traceSync,
    output logic traceFrame,
    output logic [TRACE_W-1:0] trace_in_data_bus,
    // Current pad owner, high while the trace input holds the shared pads.
    output logic traceMode
);

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    localparam int DED_W = 3 + serial_trace_pkg::DEDICATED_DATA_BITS;

    logic [SHARED-1:0] padSync;
    logic [DED_W-1:0] dedSync;
    logic selectTrace;
    serial_trace_pkg::pad_owner_t owner;
    logic [TRACE_W-1:0] next_traceData;

    pad_sync #(
        .WIDTH(SHARED)
    ) u_shared_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .asyncIn(padIn),
        .syncOut(padSync)
    );

    pad_sync #(
        .WIDTH(DED_W)
    ) u_dedicated_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .asyncIn({traceDataPins, trace_in_enable_pin, trace_in_sync_pin, trace_in_clock_pin}),
        .syncOut(dedSync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Ownership decision.

    function automatic serial_trace_pkg::pad_owner_t ownerOf(input logic spiEn,
                                                             input logic trcEn);
        if (spiEn) begin
            ownerOf = serial_trace_pkg::OWNER_SERIAL;
        end else if (trcEn) begin
            ownerOf = serial_trace_pkg::OWNER_TRACE;
        end else begin
            ownerOf = serial_trace_pkg::OWNER_SERIAL;
        end
    endfunction : ownerOf

    always_comb begin
        owner = ownerOf(serialEnable, traceEnable);
        case (owner)
            serial_trace_pkg::OWNER_SERIAL: selectTrace = 1'b0;
            serial_trace_pkg::OWNER_TRACE: selectTrace = 1'b1;
            default: selectTrace = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            traceMode <= serial_trace_pkg::TRACE_MODE_RESET;
        end else begin
            traceMode <= selectTrace;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pad drive: the serial port drives only while it owns the pads.

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            padOut <= serial_trace_pkg::PAD_RESET;
            padOe <= serial_trace_pkg::PAD_RESET;
            serialIn <= serial_trace_pkg::PAD_RESET;
        end else if (selectTrace) begin
            padOut <= '0;
            padOe <= '0;
            serialIn <= '0;
        end else begin
            padOut <= serialOut;
            padOe <= serialOe;
            serialIn <= padSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trace data assembly.

    always_comb begin
        next_traceData = '0;
        for (int b = 0; b < serial_trace_pkg::DEDICATED_DATA_BITS; b++) begin
            next_traceData[b] = dedSync[3 + b];
        end
        if (selectTrace) begin
            for (int i = 0; i < SHARED; i++) begin
                next_traceData[serial_trace_pkg::TRACE_BIT_MAP[i]] = padSync[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            trace_in_data_bus <= serial_trace_pkg::TRACE_RESET;
        end else begin
            trace_in_data_bus <= next_traceData;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            traceClock <= 1'b0;
            traceSync <= 1'b0;
            traceFrame <= 1'b0;
        end else begin
            traceClock <= dedSync[0];
            traceSync <= dedSync[1];
            traceFrame <= dedSync[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_serial_owns;
        @(posedge clk_sys) disable iff (!rst_b)
        serialEnable |=> (!traceMode && padOe == $past(serialOe) && padOut == $past(serialOut));
    endproperty
    a_serial_owns: assert property (p_serial_owns)
        else $error("Serial port enabled but pads not given to it.");

    property p_trace_owns;
        @(posedge clk_sys) disable iff (!rst_b)
        (traceEnable && !serialEnable) |=> (traceMode && padOe == '0 && serialIn == '0);
    endproperty
    a_trace_owns: assert property (p_trace_owns)
        else $error("Trace enabled alone but pads not released to it.");

    property p_idle_serial;
        @(posedge clk_sys) disable iff (!rst_b)
        (!traceEnable && !serialEnable) |=> (!traceMode && serialIn == $past(padSync));
    endproperty
    a_idle_serial: assert property (p_idle_serial)
        else $error("Idle pads not left with the serial port.");

    property p_dedicated;
        @(posedge clk_sys) disable iff (!rst_b)
        ##1 1'b1 |-> ##2 (traceClock == $past(trace_in_clock_pin, 3)
            && traceSync == $past(trace_in_sync_pin, 3)
            && traceFrame == $past(trace_in_enable_pin, 3)
            && trace_in_data_bus[1:0] == $past(traceDataPins, 3));
    endproperty
    a_dedicated: assert property (p_dedicated)
        else $error("Dedicated trace pads not passed through.");

    property p_clock_enable_map;
        @(posedge clk_sys) disable iff (!rst_b)
        traceMode |-> (trace_in_data_bus[4] == $past(padSync[0])
            && trace_in_data_bus[7] == $past(padSync[5]));
    endproperty
    a_clock_enable_map: assert property (p_clock_enable_map)
        else $error("Clock or enable pad mapped to wrong trace bit.");

    property p_cs_map;
        @(posedge clk_sys) disable iff (!rst_b)
        traceMode |-> (trace_in_data_bus[6:5] == $past(padSync[2:1])
            && trace_in_data_bus[3:2] == $past(padSync[4:3]));
    endproperty
    a_cs_map: assert property (p_cs_map)
        else $error("Chip-select pads mapped to wrong trace bits.");

    property p_out_map;
        @(posedge clk_sys) disable iff (!rst_b)
        traceMode |-> trace_in_data_bus[11:8] == $past(padSync[9:6]);
    endproperty
    a_out_map: assert property (p_out_map)
        else $error("Controller-out pads mapped to wrong trace bits.");

    property p_in_map;
        @(posedge clk_sys) disable iff (!rst_b)
        traceMode |-> trace_in_data_bus[15:12] == $past(padSync[13:10]);
    endproperty
    a_in_map: assert property (p_in_map)
        else $error("Controller-in pads mapped to wrong trace bits.");

    property p_serial_quiet;
        @(posedge clk_sys) disable iff (!rst_b)
        !traceMode |-> trace_in_data_bus[15:2] == '0;
    endproperty
    a_serial_quiet: assert property (p_serial_quiet)
        else $error("Shared trace bits active while serial port owns pads.");

endmodule : serial_trace_pin_mux

// ### serial_port_model.sv
// Behavioural model of the serial port that drives the shared pads.
`timescale 1ns/1ps
module serial_port_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Port enable and the word driven while enabled.
    input wire logic portEnable,
    input wire logic [serial_trace_pkg::SHARED_PADS-1:0] pattern,
    // Drive towards the multiplexer.
    output logic [serial_trace_pkg::SHARED_PADS-1:0] serialOut,
    output logic [serial_trace_pkg::SHARED_PADS-1:0] serialOe
);
    // A disabled port releases its pads and its stale drive value toggles, so nothing leans on it.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            serialOut <= '0;
            serialOe <= '0;
        end else if (portEnable) begin
            serialOut <= pattern;
            serialOe <= ~pattern ^ 14'h0F0F;
        end else begin
            serialOut <= ~serialOut;
            serialOe <= '0;
        end
    end
endmodule : serial_port_model

// ### tb.sv
// Self-checking testbench for the serial/trace pad multiplexer.
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic serialEnable = 1'b0;
    logic traceEnable = 1'b0;
    logic [13:0] pattern = 14'h1A6C;
    logic [13:0] serialOut, serialOe, serialIn, padOut, padOe;
    logic [13:0] padIn = 14'h0000;
    logic tClk = 1'b0;
    logic tSync = 1'b0;
    logic tEna = 1'b0;
    logic [1:0] tData = 2'b00;
    logic traceClock, traceSync, traceFrame, traceMode;
    logic [15:0] traceData;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int bitMap [14] = '{4, 5, 6, 2, 3, 7, 8, 9, 10, 11, 12, 13, 14, 15};

    serial_port_model serial_port_model_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .portEnable(serialEnable), .pattern(pattern), .serialOut(serialOut), .serialOe(serialOe));

    serial_trace_pin_mux serial_trace_pin_mux_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .serialEnable(serialEnable), .traceEnable(traceEnable), .serialOut(serialOut),
        .serialOe(serialOe), .serialIn(serialIn), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .trace_in_clock_pin(tClk), .trace_in_sync_pin(tSync), .trace_in_enable_pin(tEna),
        .traceDataPins(tData), .traceClock(traceClock), .traceSync(traceSync),
        .traceFrame(traceFrame), .trace_in_data_bus(traceData), .traceMode(traceMode));

    always #12.5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    // Ends the run with a mismatch if the tests hang.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    // Sets the enables and new dedicated pad levels, then waits for everything to pass through.
    task automatic set_mode(input logic s, input logic t, input logic [4:0] ded);
        logic [4:0] got;
        @(posedge clk_sys);
        serialEnable <= s;
        traceEnable <= t;
        {tClk, tSync, tEna, tData} <= ded;
        settle(4);
        got = {traceClock, traceSync, traceFrame, traceData[1:0]};
        check(got, ded, "dedicated pads");
    endtask : set_mode

    ////////////////////////////////////////////////////////////////////////////////
    task automatic trace_map_test();
        set_mode(1'b0, 1'b1, 5'h15);
        check(traceMode, 1'b1, "trace owner");
        for (int i = 0; i < 14; i++) begin
            @(posedge clk_sys);
            padIn <= 14'h0001 << i;
            settle(3);
            check(traceData, (16'h0001 << bitMap[i]) | 16'h0001, "trace bit");
            check(padOe, 14'h0000, "pads released");
            check(padOut, 14'h0000, "pad drive off");
            check(serialIn, 14'h0000, "serial input");
        end
    endtask : trace_map_test

    task automatic serial_owner_test(input logic t, input logic [4:0] ded);
        logic [13:0] so, soe;
        set_mode(1'b1 & t | !t & ded[0], t, ded);
        @(posedge clk_sys);
        padIn <= 14'h2A5C;
        settle(3);
        so = serialOut;
        soe = serialOe;
        @(negedge clk_sys);
        check(traceMode, 1'b0, "serial owner");
        check(padOut, so, "pad drive");
        check(padOe, soe, "pad enable");
        check(serialIn, 14'h2A5C, "serial input");
        check(traceData[15:2], 14'h0000, "shared trace bits");
    endtask : serial_owner_test

    initial begin
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        trace_map_test();
        serial_owner_test(1'b1, 5'h0A);
        trace_map_test();
        serial_owner_test(1'b0, 5'h12);
        serial_owner_test(1'b0, 5'h0B);
        print_verdict();
    end
endmodule : tb
